// ===== verilog/sld_map.svh
// Register offsets, field positions, reset values and timing counts
//
// Contract
// - Sleep bit stops driver while asleep
// - Error flag sets on disallowed pixel write
// - Control bit 4 always reads zero
// - Reset loads zeros, common count 11
// - Common count picks static to quarter multiplex
// - Unused commons stay idle
// - Common pins in use ignore their direction bit
// - Digital pins follow their direction bit
// - Segment drives only when its enable set
// - Segment enable overrides direction bit while driver runs
// - After reset all shared pins are I/O
// - One pixel bit per common-segment crossing
// - Unused pixel bits are plain storage
// - Common 3 and segment 15 share a pin
// - Interrupt pulse when driver finishes stopping
// - Disallowed pixel write is discarded
// - Frame rate divides clock by factor, prescale, 32
`ifndef SLD_MAP_SVH
`define SLD_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SLD_OFS_CTRL       8'h00
`define SLD_OFS_PRESCALE   8'h01
`define SLD_OFS_SEGEN0     8'h02
`define SLD_OFS_SEGEN1     8'h03
`define SLD_OFS_STATUS     8'h04
`define SLD_OFS_PIXEL0     8'h10
`define SLD_OFS_PIXEL_LAST 8'h17
`define SLD_OFS_DIR0       8'h20
`define SLD_OFS_DIR1       8'h21
`define SLD_OFS_DIR2       8'h22

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define SLD_CTRL_ON_BIT    7
`define SLD_CTRL_SLEEP_BIT 6
`define SLD_CTRL_PIXEL_WRITE_ERROR_BIT  5
`define SLD_CTRL_RSV_BIT   4
`define SLD_CTRL_RESET     8'h03
`define SLD_PS_WA_BIT      4
`define SLD_PS_RESET       8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SLD_SYSDIV         9'd256
`define SLD_FRAME_BASE     8'd32
`define SLD_NUM_COM        4
`define SLD_NUM_SEG        16
`define SLD_NUM_PIX        8

`endif

// ===== verilog/sld_pkg.sv
// Types for the segment display driver control block
`default_nettype none
package sld_pkg;
  typedef enum logic [1:0] {
    SLD_MUX_STATIC  = 2'h0,
    SLD_MUX_HALF    = 2'h1,
    SLD_MUX_THIRD   = 2'h2,
    SLD_MUX_QUARTER = 2'h3
  } sld_mux_t;

  typedef enum logic [1:0] {
    SLD_ST_IDLE     = 2'h0,
    SLD_ST_RUN      = 2'h1,
    SLD_ST_STOPPING = 2'h2
  } sld_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sld_bus_t;

  typedef struct packed {
    logic       on;
    logic       sleep_off;
    logic [1:0] clk_sel;
    sld_mux_t   mux;
  } sld_ctrl_t;
endpackage : sld_pkg
`default_nettype wire

// ===== verilog/sld_pixel_mem.sv
// Pixel data storage, eight bytes, registered read
`default_nettype none
module sld_pixel_mem (
  input  wire logic        core_clk_i,
  input  wire logic        we_i,
  input  wire logic [2:0]  waddr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic [2:0]  raddr_i,
  output logic      [7:0]  rdata_o,
  output logic      [63:0] all_o
);
  logic [7:0] mem_ff [0:7];

  // Contents survive reset like general storage
  always_ff @(posedge core_clk_i) begin
    if (we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    rdata_o <= mem_ff[raddr_i];
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      all_o[i*8 +: 8] = mem_ff[i];
    end
  end
endmodule // sld_pixel_mem
`default_nettype wire

// ===== verilog/sld_timebase.sv
// Clock source selection and frame timing enables
`include "sld_map.svh"
`default_nettype none
module sld_timebase (
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       run_i,
  input  wire logic [1:0] clk_sel_i,
  input  wire logic       sec_tick_i,
  input  wire logic       lf_tick_i,
  input  wire logic [3:0] prescale_i,
  input  wire logic [1:0] mux_i,
  output logic            phase_en_o,
  output logic [1:0]      com_idx_o
);
  logic [8:0] div_ff;
  logic       src_tick;
  logic [3:0] ps_ff;
  logic [7:0] sub_ff;
  logic [1:0] com_ff;
  logic [9:0] phase_len;

  // ----------------------------------------------------------------------
  // Source select
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || !run_i) div_ff <= 9'h000;
    else if (div_ff == `SLD_SYSDIV - 9'd1) div_ff <= 9'h000;
    else div_ff <= div_ff + 9'd1;
  end

  always_comb begin
    unique casez (clk_sel_i)
      2'b00:   src_tick = (div_ff == `SLD_SYSDIV - 9'd1);
      2'b01:   src_tick = sec_tick_i;
      default: src_tick = lf_tick_i;
    endcase
  end

  // ----------------------------------------------------------------------
  // Prescaler, then 32 ticks per common phase, scaled by multiplex
  // ----------------------------------------------------------------------
  // Factor times commons gives 4 for static and halves, 3 for thirds
  assign phase_len = (mux_i == 2'h0) ? 10'd128 :
                     (mux_i == 2'h1) ? 10'd64  :
                     (mux_i == 2'h2) ? 10'd32  : 10'd32;

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || !run_i) ps_ff <= 4'h0;
    else if (src_tick) ps_ff <= (ps_ff == prescale_i) ? 4'h0 : ps_ff + 4'h1;
  end

  assign phase_en_o = src_tick && (ps_ff == prescale_i) &&
                      ({2'b00, sub_ff} == phase_len - 10'd1);

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || !run_i) sub_ff <= 8'h00;
    else if (phase_en_o) sub_ff <= 8'h00;
    else if (src_tick && ps_ff == prescale_i) sub_ff <= sub_ff + 8'h01;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || !run_i) com_ff <= 2'h0;
    else if (phase_en_o) com_ff <= (com_ff == mux_i) ? 2'h0 : com_ff + 2'h1;
  end

  assign com_idx_o = com_ff;
endmodule // sld_timebase
`default_nettype wire

// ===== verilog/sld_ctrl.sv
// Top of segment display driver control: registers, pin muxing, drive
`include "sld_map.svh"
`default_nettype none
module sld_ctrl (
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  input  wire logic        sleep_i,
  input  wire logic        sec_osc_i,
  input  wire logic        lf_osc_i,
  output logic      [3:0]  com_drive_o,
  output logic      [3:0]  com_active_o,
  output logic      [15:0] seg_drive_o,
  output logic      [15:0] seg_active_o,
  output logic      [19:0] pin_oen_o,
  output logic             driver_active_o,
  output logic             stop_irq_o
);
  sld_pkg::sld_bus_t   bus;
  sld_pkg::sld_ctrl_t  ctrl_ff;
  sld_pkg::sld_state_t state_ff;
  logic        pixel_write_error_ff;
  logic [7:0]  ps_ff;
  logic [15:0] segen_ff;
  logic [19:0] dir_ff;
  logic [2:0]  sec_sync_ff;
  logic [2:0]  lf_sync_ff;
  logic        run;
  logic        phase_en;
  logic [1:0]  com_idx;
  logic        pix_hit;
  logic        pix_we;
  logic [7:0]  pix_rdata;
  logic [63:0] pix_all;
  logic        rd_pix_ff;
  logic [7:0]  rd_reg_ff;
  logic        act_ff;
  logic [3:0]  com_used;
  logic [15:0] seg_used;

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  function automatic logic [3:0] com_mask(input logic [1:0] mux);
    com_mask = {mux == 2'h3, mux[1], mux != 2'h0, 1'b1};
  endfunction

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      ctrl_ff <= '{on: 1'b0, sleep_off: 1'b0, clk_sel: 2'h0,
                   mux: sld_pkg::SLD_MUX_QUARTER};
    end else if (bus.wr && bus.addr == `SLD_OFS_CTRL) begin
      ctrl_ff.on        <= bus.wdata[`SLD_CTRL_ON_BIT];
      ctrl_ff.sleep_off <= bus.wdata[`SLD_CTRL_SLEEP_BIT];
      ctrl_ff.clk_sel   <= bus.wdata[3:2];
      ctrl_ff.mux       <= sld_pkg::sld_mux_t'(bus.wdata[1:0]);
    end
  end

  // ----------------------------------------------------------------------
  // Write error flag: set wins over software clear
  // ----------------------------------------------------------------------
  assign pix_hit = bus.addr >= `SLD_OFS_PIXEL0 && bus.addr <= `SLD_OFS_PIXEL_LAST;
  // Writes lock only while running; disabled driver accepts them
  assign pix_we  = bus.wr && pix_hit && (!run || ps_ff[`SLD_PS_WA_BIT]);

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) pixel_write_error_ff <= 1'b0;
    else if (bus.wr && pix_hit && run && !ps_ff[`SLD_PS_WA_BIT]) pixel_write_error_ff <= 1'b1;
    else if (bus.wr && bus.addr == `SLD_OFS_CTRL && !bus.wdata[`SLD_CTRL_PIXEL_WRITE_ERROR_BIT])
      pixel_write_error_ff <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Prescale, segment enable and direction registers
  // ----------------------------------------------------------------------
  // Write-allowed flag is software held here; no frame sequencing
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) ps_ff <= `SLD_PS_RESET;
    else if (bus.wr && bus.addr == `SLD_OFS_PRESCALE) ps_ff <= bus.wdata;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) segen_ff <= 16'h0000;
    else if (bus.wr && bus.addr == `SLD_OFS_SEGEN0) segen_ff[7:0]  <= bus.wdata;
    else if (bus.wr && bus.addr == `SLD_OFS_SEGEN1) segen_ff[15:8] <= bus.wdata;
  end

  // Direction bits: 1 means input, as on a port
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) dir_ff <= 20'hFFFFF;
    else if (bus.wr && bus.addr == `SLD_OFS_DIR0) dir_ff[7:0]   <= bus.wdata;
    else if (bus.wr && bus.addr == `SLD_OFS_DIR1) dir_ff[15:8]  <= bus.wdata;
    else if (bus.wr && bus.addr == `SLD_OFS_DIR2) dir_ff[19:16] <= bus.wdata[3:0];
  end

  // ----------------------------------------------------------------------
  // Run control and stop event
  // ----------------------------------------------------------------------
  assign run = ctrl_ff.on && !(sleep_i && ctrl_ff.sleep_off);

  // Driver stays active one STOPPING cycle after run drops, then goes inactive
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) state_ff <= sld_pkg::SLD_ST_IDLE;
    else begin
      unique case (state_ff)
        sld_pkg::SLD_ST_IDLE:     if (run) state_ff <= sld_pkg::SLD_ST_RUN;
        sld_pkg::SLD_ST_RUN:      if (!run) state_ff <= sld_pkg::SLD_ST_STOPPING;
        sld_pkg::SLD_ST_STOPPING: state_ff <= run ? sld_pkg::SLD_ST_RUN
                                                  : sld_pkg::SLD_ST_IDLE;
        default:                  state_ff <= sld_pkg::SLD_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) act_ff <= 1'b0;
    else act_ff <= (state_ff != sld_pkg::SLD_ST_IDLE);
  end

  assign driver_active_o = act_ff;
  assign stop_irq_o = act_ff && (state_ff == sld_pkg::SLD_ST_IDLE);

  // ----------------------------------------------------------------------
  // Oscillator tick synchronisers, edge taken after second stage
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      sec_sync_ff <= 3'h0;
      lf_sync_ff  <= 3'h0;
    end else begin
      sec_sync_ff <= {sec_sync_ff[1:0], sec_osc_i};
      lf_sync_ff  <= {lf_sync_ff[1:0], lf_osc_i};
    end
  end

  sld_timebase u_timebase (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .run_i      (run),
    .clk_sel_i  (ctrl_ff.clk_sel),
    .sec_tick_i (sec_sync_ff[1] && !sec_sync_ff[2]),
    .lf_tick_i  (lf_sync_ff[1] && !lf_sync_ff[2]),
    .prescale_i (ps_ff[3:0]),
    .mux_i      (ctrl_ff.mux),
    .phase_en_o (phase_en),
    .com_idx_o  (com_idx)
  );

  // ----------------------------------------------------------------------
  // Pixel memory
  // ----------------------------------------------------------------------
  sld_pixel_mem u_pixel_mem (
    .core_clk_i (core_clk_i),
    .we_i       (pix_we),
    .waddr_i    (bus.addr[2:0]),
    .wdata_i    (bus.wdata),
    .raddr_i    (bus.addr[2:0]),
    .rdata_o    (pix_rdata),
    .all_o      (pix_all)
  );

  // ----------------------------------------------------------------------
  // Common and segment drive
  // ----------------------------------------------------------------------
  // Common 3 shares the segment 15 pin; common use wins there
  assign com_used = run ? com_mask(ctrl_ff.mux) : 4'h0;
  assign seg_used = run ? (segen_ff & ~{com_used[3], 15'h0000}) : 16'h0000;

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || !run) begin
      com_drive_o <= 4'h0;
      seg_drive_o <= 16'h0000;
    end else begin
      com_drive_o <= com_used & (4'h1 << com_idx);
      // Byte pairs hold one common: bytes 2c and 2c+1 are segments 0..15
      seg_drive_o <= pix_all[com_idx*16 +: 16] & seg_used;
    end
  end

  // Registered beside the drives so both fall on the same edge at stop
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) com_active_o <= 4'h0;
    else com_active_o <= com_used;
  end

  assign seg_active_o = seg_used;

  // Pins 0..15 segments, 16..18 commons 0..2, common 3 on pin 15, 19 I/O only
  always_comb begin
    pin_oen_o = dir_ff;
    for (int i = 0; i < 16; i++) begin
      if (seg_used[i]) pin_oen_o[i] = 1'b0;
    end
    for (int c = 0; c < 3; c++) begin
      if (com_used[c]) pin_oen_o[16 + c] = 1'b0;
    end
    if (com_used[3]) pin_oen_o[15] = 1'b0;
  end

  // ----------------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      rd_reg_ff <= 8'h00;
      rd_pix_ff <= 1'b0;
    end else begin
      rd_pix_ff <= bus.rd && pix_hit;
      unique case (bus.addr)
        `SLD_OFS_CTRL:     rd_reg_ff <= {ctrl_ff.on, ctrl_ff.sleep_off, pixel_write_error_ff, 1'b0,
                                         ctrl_ff.clk_sel, ctrl_ff.mux};
        `SLD_OFS_PRESCALE: rd_reg_ff <= ps_ff;
        `SLD_OFS_SEGEN0:   rd_reg_ff <= segen_ff[7:0];
        `SLD_OFS_SEGEN1:   rd_reg_ff <= segen_ff[15:8];
        `SLD_OFS_STATUS:   rd_reg_ff <= {7'h00, act_ff};
        `SLD_OFS_DIR0:     rd_reg_ff <= dir_ff[7:0];
        `SLD_OFS_DIR1:     rd_reg_ff <= dir_ff[15:8];
        `SLD_OFS_DIR2:     rd_reg_ff <= {4'h0, dir_ff[19:16]};
        default:           rd_reg_ff <= 8'h00;
      endcase
    end
  end

  assign rdata_o = rd_pix_ff ? pix_rdata : rd_reg_ff;
endmodule // sld_ctrl
`default_nettype wire

// ===== bench/sld_ctrl_properties.sv
// Port-level assertions for the display control block
`default_nettype none
module sld_ctrl_properties (
  input wire logic        core_clk_i,
  input wire logic        rstn_i,
  input wire logic [7:0]  addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  input wire logic        sleep_i,
  input wire logic [3:0]  com_drive_o,
  input wire logic [3:0]  com_active_o,
  input wire logic [15:0] seg_active_o,
  input wire logic [19:0] pin_oen_o,
  input wire logic        driver_active_o,
  input wire logic        stop_irq_o
);
  // ----------------------------------------------------------------
  // Shadow of the control bits
  // ----------------------------------------------------------------
  logic on_ff;
  logic slp_ff;
  logic wa_ff;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      on_ff  <= 1'b0;
      slp_ff <= 1'b0;
      wa_ff  <= 1'b0;
    end else if (wr_i && addr_i == 8'h00) begin
      on_ff  <= wdata_i[7];
      slp_ff <= wdata_i[6];
    end else if (wr_i && addr_i == 8'h01) begin
      wa_ff <= wdata_i[4];
    end
  end
  sequence s_bad_wr;
    wr_i && addr_i[7:3] == 5'h02 && on_ff && !(sleep_i && slp_ff) && !wa_ff;
  endsequence
  sequence s_ctl_rd;
    rd_i && addr_i == 8'h00;
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_PIXEL_WRITE_ERROR_SET: assert property (s_bad_wr ##1 !wr_i ##1 s_ctl_rd |=> rdata_o[5])
    else $error("error flag not set");
  AST_RSV_ZERO: assert property (s_ctl_rd |=> !rdata_o[4])
    else $error("reserved bit reads one");
  AST_COM_USED: assert property ((com_drive_o & ~com_active_o) == 4'h0)
    else $error("unused common driven");
  AST_COMMON_LINE_3_SEGMENT_LINE_15: assert property (com_active_o[3] |-> !seg_active_o[15])
    else $error("shared pin used twice");
  AST_SEG_PIN: assert property ($stable(seg_active_o) |->
    (seg_active_o & pin_oen_o[15:0]) == 16'h0000) else $error("segment pin not driven");
  AST_COM_PIN: assert property (on_ff && $past(on_ff, 4) && !sleep_i |->
    (com_drive_o[2:0] & pin_oen_o[18:16]) == 3'h0) else $error("common pin not driven");
  AST_IDLE: assert property ((!on_ff && !driver_active_o) [*2] |-> com_drive_o == 4'h0)
    else $error("common driven while off");
  AST_STOP: assert property (wr_i && addr_i == 8'h00 && !wdata_i[7] && driver_active_o
    |-> ##[1:4] !driver_active_o) else $error("driver did not stop");
  AST_SLEEP_STOP: assert property ($rose(sleep_i) && slp_ff && on_ff
    |-> ##[1:5] !driver_active_o) else $error("driver ran in sleep");
  AST_RUN: assert property ((on_ff && !(sleep_i && slp_ff)) [*5] |-> driver_active_o)
    else $error("driver not active");
  AST_IRQ: assert property (stop_irq_o |-> driver_active_o ##1 !driver_active_o)
    else $error("stop pulse misplaced");
endmodule // sld_ctrl_properties
`default_nettype wire

// ===== bench/sld_panel.sv
// Passive glass model latching segment levels under each common
`default_nettype none
module sld_panel (
  input  wire logic        core_clk_i,
  input  wire logic [3:0]  com_i,
  input  wire logic [15:0] seg_i,
  output logic      [63:0] pix_o
);
  always_ff @(posedge core_clk_i) begin
    for (int c = 0; c < 4; c++) begin
      if (com_i == 4'(1 << c)) begin
        pix_o[c*16 +: 16] <= seg_i;
      end
    end
  end
endmodule // sld_panel
`default_nettype wire

// ===== bench/sld_ctrl_tb.sv
// Self-checking bench for the display control block
`default_nettype none
module sld_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 60000; // Slowest case is the sysclk/256 phase
  logic        core_clk_i, rstn_i, wr_i, rd_i, sleep_i, sec_osc_i, lf_osc_i;
  logic [7:0]  addr_i, wdata_i, rdata_o;
  logic [3:0]  com_drive_o, com_active_o;
  logic [15:0] seg_drive_o, seg_active_o;
  logic [19:0] pin_oen_o;
  logic        driver_active_o, stop_irq_o, sec_en, lf_en;
  logic [63:0] pix;
  logic [2:0]  div;
  int          mismatches, checks, cycles, irqs, irq0;
  sld_ctrl dut (.core_clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sleep_i,
    .sec_osc_i, .lf_osc_i, .com_drive_o, .com_active_o, .seg_drive_o, .seg_active_o,
    .pin_oen_o, .driver_active_o, .stop_irq_o);
  sld_panel panel (.core_clk_i, .com_i(com_drive_o), .seg_i(seg_drive_o), .pix_o(pix));
  // ----------------------------------------------------------------
  // Clock, oscillators, watchdog
  // ----------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    div       <= div + 3'h1;
    sec_osc_i <= sec_en & div[2];
    lf_osc_i  <= lf_en & div[2];
    cycles++;
    if (stop_irq_o === 1'b1) irqs++;
    if (cycles == LIMIT) begin
      mismatches++;
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [7:0] pat(input int i);
    return 8'(i * 37 + 5);
  endfunction
  task automatic chk(input string s, input logic [19:0] e, input logic [19:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    @(negedge core_clk_i);
    chk($sformatf("reg %h", a), 20'(e), 20'(rdata_o));
    @(posedge core_clk_i);
  endtask
  task automatic phase(output int len);
    logic [3:0] c;
    for (int k = 0; k < 2; k++) begin
      c = com_drive_o;
      len = 0;
      while (com_drive_o === c && len < 9000) begin
        @(posedge core_clk_i);
        len++;
      end
    end
  endtask
  // Off, configure, then enable: mux is never changed while running
  task automatic run_cfg(input logic [1:0] cs, input logic [1:0] m, input int el);
    int len;
    wr(8'h00, 8'h00);
    wr(8'h00, {4'h0, cs, m});
    wr(8'h00, {4'h8, cs, m});
    repeat (6) @(posedge core_clk_i);
    chk("active", 20'h1, 20'(driver_active_o));
    chk("com used", {16'h0, m == 2'h3, m[1], m != 2'h0, 1'b1}, 20'(com_active_o));
    chk("seg used", {4'h0, m != 2'h3, 15'h7FFF}, 20'(seg_active_o));
    chk("pins", {1'b1, !m[1], m == 2'h0, 17'h0}, pin_oen_o);
    if (m == 2'h0) chk("static com", 20'h1, 20'(com_drive_o));
    if (el > 0) begin
      phase(len);
      chk("phase", 20'h1, 20'(len > el - 9 && len < el + 9));
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn_i, wr_i, rd_i, sleep_i, sec_osc_i, lf_osc_i, sec_en, lf_en} = 8'h00;
    {addr_i, wdata_i, div} = 19'h0;
    repeat (2) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    @(posedge core_clk_i);
    chk("reset pins", 20'hFFFFF, pin_oen_o);
    rdc(8'h00, 8'h03);
    rdc(8'h04, 8'h00);
    wr(8'h00, 8'h7F);
    rdc(8'h00, 8'h4F);
    wr(8'h3F, 8'hFF);
    rdc(8'h3F, 8'h00);
    wr(8'h20, 8'hA5);
    wr(8'h21, 8'h3C);
    wr(8'h22, 8'h0F);
    chk("io pins", 20'hF3CA5, pin_oen_o);
    for (int i = 0; i < 8; i++) wr(8'(8'h10 + i), pat(i));
    for (int i = 0; i < 8; i++) rdc(8'(8'h10 + i), pat(i));
    wr(8'h02, 8'hFF);
    wr(8'h03, 8'hFF);
    wr(8'h01, 8'h00);
    lf_en <= 1'b1;
    run_cfg(2'h2, 2'h3, 256);
    repeat (1100) @(posedge core_clk_i);
    for (int c = 0; c < 4; c++) begin
      chk("pixel", 20'({pat(2*c+1), pat(2*c)} & 16'h7FFF), 20'(pix[c*16 +: 16]));
    end
    sleep_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    chk("sleep run", 20'h1, 20'(driver_active_o));
    sleep_i <= 1'b0;
    wr(8'h00, 8'hCB);
    irq0 = irqs;
    sleep_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    chk("sleep stop", 20'h0, 20'(driver_active_o));
    chk("sleep com", 20'h0, 20'(com_drive_o));
    chk("stop pulses", 20'h1, 20'(irqs - irq0));
    sleep_i <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    chk("wake", 20'h1, 20'(driver_active_o));
    wr(8'h10, 8'h00);
    rdc(8'h00, 8'hEB);
    rdc(8'h10, pat(0));
    wr(8'h00, 8'h8B);
    rdc(8'h00, 8'h8B);
    wr(8'h01, 8'h10);
    wr(8'h10, 8'h5A);
    rdc(8'h10, 8'h5A);
    rdc(8'h00, 8'h8B);
    wr(8'h01, 8'h00);
    run_cfg(2'h3, 2'h0, 0);
    run_cfg(2'h3, 2'h1, 512);
    run_cfg(2'h3, 2'h2, 256);
    lf_en  <= 1'b0;
    sec_en <= 1'b1;
    run_cfg(2'h1, 2'h3, 256);
    wr(8'h01, 8'h01);
    run_cfg(2'h1, 2'h3, 512);
    sec_en <= 1'b0;
    wr(8'h01, 8'h00);
    run_cfg(2'h0, 2'h3, 8192);
    irq0 = irqs;
    wr(8'h00, 8'h03);
    repeat (6) @(posedge core_clk_i);
    chk("off", 20'h0, 20'(driver_active_o));
    chk("off pulses", 20'h1, 20'(irqs - irq0));
    chk("off pins", 20'hF3CA5, pin_oen_o);
    complete_run();
  end
endmodule // sld_ctrl_tb
bind sld_ctrl sld_ctrl_properties u_props (.core_clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .sleep_i, .com_drive_o, .com_active_o, .seg_active_o, .pin_oen_o,
  .driver_active_o, .stop_irq_o);
`default_nettype wire
